// File: src/rdc_pkg.sv
package rdc_pkg;
  localparam int RDC_DW = 16;
  localparam int RDC_CW = 18;
  localparam int RDC_AW = 48;
  localparam logic signed [RDC_AW-1:0] RDC_SMAX = 48'sh0000_0000_7fff;
  localparam logic signed [RDC_AW-1:0] RDC_SMIN = -48'sh0000_0000_8000;
  localparam logic [7:0] RDC_OFF_CTRL = 8'h00;
  localparam logic [7:0] RDC_OFF_BAND_A = 8'h04;
  localparam logic [7:0] RDC_OFF_BAND_B = 8'h08;
  localparam logic [7:0] RDC_OFF_FREQ_A = 8'h0c;
  localparam logic [7:0] RDC_OFF_FREQ_B = 8'h10;
  localparam logic [7:0] RDC_OFF_COEF_ADDR = 8'h14;
  localparam logic [7:0] RDC_OFF_COEF_DATA = 8'h18;
  localparam logic [7:0] RDC_OFF_STATUS = 8'h1c;
  localparam int RDC_CTRL_W = 14;
  localparam int RDC_CB_DECIMATE_BY_FIVE_FILTER = 0;
  localparam int RDC_CB_EARLY = 1;
  localparam int RDC_CB_LATE = 2;
  localparam int RDC_CB_HB2 = 3;
  localparam int RDC_CB_HB1 = 4;
  localparam int RDC_CB_WIDE = 5;
  localparam int RDC_CB_PDEC = 6;
  localparam int RDC_CB_PTAP = 8;
  localparam int RDC_CB_GAIN = 10;
  localparam int RDC_CB_REAL = 12;
  localparam int RDC_CB_DUAL = 13;
  localparam int RDC_BAND_W = 5;
  localparam int RDC_BB_OSC1 = 0;
  localparam int RDC_BB_OSC2 = 1;
  localparam int RDC_BB_HB = 2;
  localparam int RDC_BB_DEC2 = 3;
  localparam int RDC_BB_INTERP = 4;
  localparam int RDC_ST_CLIP = 16;
  localparam logic [RDC_CTRL_W-1:0] RDC_CTRL_RST = 14'h0000;
  localparam logic [2:0] RDC_DECIM_1 = 3'h1;
  localparam logic [2:0] RDC_DECIM_2 = 3'h2;
  localparam logic [2:0] RDC_DECIM_4 = 3'h4;
  localparam logic [2:0] RDC_DECIM_5 = 3'h5;
  localparam logic [2:0] RDC_DPDIV_CASCADE = 3'h4;
  localparam logic [2:0] RDC_DPDIV_DECIMATE_BY_FIVE_FILTER = 3'h5;
  localparam int RDC_DECIMATE_BY_FIVE_FILTER_N = 32;
  localparam int RDC_BINO_N = 5;
  localparam int RDC_HB3_N = 7;
  localparam int RDC_HB2_N = 13;
  localparam int RDC_HB1_N = 25;
  localparam int RDC_HB1LP_N = 15;
  localparam int RDC_PROGRAMMABLE_FIR_N = 72;
  localparam int RDC_IFHB_N = 55;
  localparam logic [6:0] RDC_TAPS_24 = 7'h18;
  localparam logic [6:0] RDC_TAPS_48 = 7'h30;
  localparam logic [6:0] RDC_TAPS_72 = 7'h48;
  localparam logic [4:0] RDC_SH_DECIMATE_BY_FIVE_FILTER = 5'h0c;
  localparam logic [4:0] RDC_SH_BINO = 5'h04;
  localparam logic [4:0] RDC_SH_HB3 = 5'h0a;
  localparam logic [4:0] RDC_SH_HB2 = 5'h0c;
  localparam logic [4:0] RDC_SH_HB1 = 5'h10;
  localparam logic [4:0] RDC_SH_IFHB = 5'h10;
  localparam logic [4:0] RDC_SH_P6 = 5'h0e;
  localparam logic [4:0] RDC_SH_0 = 5'h0f;
  localparam logic [4:0] RDC_SH_M6 = 5'h10;
  localparam logic [4:0] RDC_SH_M12 = 5'h11;
  localparam int RDC_OSC_SH = 14;
  // integer coefficients, scale 2^shift of each stage
  localparam int RDC_DECIMATE_BY_FIVE_FILTER_C [RDC_DECIMATE_BY_FIVE_FILTER_N] = '{4, 5, 8, 8, -16, -32, -60, -77, -78, -31, 44,
    171, 324, 480, 602, 678, 602, 480, 324, 171, 44, -31, -78, -77, -60, -32, -16, 5, 8, 8,
    5, 4};
  localparam int RDC_BINO_C [RDC_BINO_N] = '{1, 4, 6, 4, 1};
  localparam int RDC_HB3_C [RDC_HB3_N] = '{-34, 0, 288, 508, 288, 0, -34};
  localparam int RDC_HB2_C [RDC_HB2_N] = '{-1, 0, 7, 0, -32, 0, 110, 0, -32, 0, 7, 0, -1};
  localparam int RDC_HB1HR_C [RDC_HB1_N] = '{7, 0, -19, 0, 41, 0, -79, 0, 139, 0, -229, 0,
    360, 0, -544, 0, 800, 0, -1156, 0, 1760, 20611, 32503, 20611, 7};
  localparam int RDC_HB1LP_C [RDC_HB1_N] = '{-176, 0, 1136, 0, -4480, 0, 19952, 32880,
    19952, 0, -4480, 0, 1136, 0, -176, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam int RDC_IFHB_C [RDC_IFHB_N] = '{-6, 0, 16, 0, -38, 0, 79, 0, -151, 0, 262, 0,
    -426, 0, 675, 0, -1029, 0, 1547, 0, -2340, 0, 3690, 0, -6652, 0, 20762, 32768, 20762, 0,
    -6652, 0, 3690, 0, -2340, 0, 1547, 0, -1029, 0, 675, 0, -426, 0, 262, 0, -151, 0, 79, 0,
    -38, 0, 16, 0, -6};
  localparam int RDC_COS_LUT [16] = '{16383, 15136, 11585, 6270, 0, -6270, -11585, -15136,
    -16383, -15136, -11585, -6270, 0, 6270, 11585, 15136};
  localparam logic [3:0] RDC_SIN_OFS = 4'hc;

  function automatic logic signed [RDC_DW-1:0] rdc_sat16(input logic signed [RDC_AW-1:0] v);
    if (v > RDC_SMAX)
      return 16'sh7fff;
    else if (v < RDC_SMIN)
      return -16'sh8000;
    else
      return v[RDC_DW-1:0];
  endfunction
endpackage

// File: src/rdc_fir_stage.sv
module rdc_fir_stage
  import rdc_pkg::*;
#(
  parameter int NT = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic signed [RDC_DW-1:0] in_i,
  input wire logic signed [RDC_DW-1:0] in_q,
  input wire logic bypass,
  input wire logic [2:0] decim,
  input wire logic [6:0] ntaps,
  input wire logic [4:0] shift,
  input wire logic [NT-1:0][RDC_CW-1:0] coef,
  output logic out_valid,
  output logic signed [RDC_DW-1:0] out_i,
  output logic signed [RDC_DW-1:0] out_q,
  output logic clip
);
  typedef struct packed {
    logic [NT-1:0][RDC_DW-1:0] hist_i;
    logic [NT-1:0][RDC_DW-1:0] hist_q;
    logic [2:0] phase;
    logic ov;
    logic [RDC_DW-1:0] oi;
    logic [RDC_DW-1:0] oq;
    logic clip;
  } rdc_fir_state_type;

  rdc_fir_state_type s_reg;
  rdc_fir_state_type s_next;

  always_comb
  begin
    logic signed [RDC_AW-1:0] acc_i;
    logic signed [RDC_AW-1:0] acc_q;
    logic signed [RDC_DW+RDC_CW-1:0] prod;
    acc_i = '0;
    acc_q = '0;
    prod = '0;
    s_next = s_reg;
    s_next.ov = 1'b0;
    s_next.clip = 1'b0;
    if (in_valid)
    begin
      if (bypass)
      begin
        s_next.oi = in_i;
        s_next.oq = in_q;
        s_next.ov = 1'b1;
      end
      else
      begin
        s_next.hist_i = {s_reg.hist_i[NT-2:0], in_i};
        s_next.hist_q = {s_reg.hist_q[NT-2:0], in_q};
        if (3'(s_reg.phase + 3'h1) >= decim)
        begin
          s_next.phase = 3'h0;
          for (int k = 0; k < NT; k++)
          begin
            if (7'(k) < ntaps)
            begin
              prod = $signed(coef[k]) * $signed(s_next.hist_i[k]);
              acc_i = acc_i + RDC_AW'(prod);
              prod = $signed(coef[k]) * $signed(s_next.hist_q[k]);
              acc_q = acc_q + RDC_AW'(prod);
            end
          end
          acc_i = acc_i >>> shift;
          acc_q = acc_q >>> shift;
          s_next.oi = rdc_sat16(acc_i);
          s_next.oq = rdc_sat16(acc_q);
          s_next.clip = (acc_i > RDC_SMAX) || (acc_i < RDC_SMIN) ||
                        (acc_q > RDC_SMAX) || (acc_q < RDC_SMIN);
          s_next.ov = 1'b1;
        end
        else
          s_next.phase = 3'(s_reg.phase + 3'h1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign out_valid = s_reg.ov;
  assign out_i = s_reg.oi;
  assign out_q = s_reg.oq;
  assign clip = s_reg.clip;
endmodule // rdc_fir_stage

// File: src/rdc_decimation_chain.sv
// Functional notes
// - A channel uses the decimate-by-five filter or the binomial cascade, never both.
// - Decimate-by-five divides rate by five; cascade gives two, four or eight.
// - Decimate-by-five uses its fixed thirty-two tap coefficient set.
// - Early binomial is 1-4-6-4-1 over sixteen, decimates by two or bypasses.
// - Late binomial uses same coefficients, independently decimates or bypasses.
// - Third half-band is a fixed seven-tap filter, always decimating by two.
// - Second half-band is fixed thirteen taps, decimates by two or bypasses.
// - First half-band high-rejection variant uses fixed taps, decimates or bypasses.
// - First half-band low-power variant uses fifteen fixed taps, decimates or bypasses.
// - Programmable FIR decimates by one, two or four, or is fully bypassed.
// - Programmable FIR runs with 24, 48 or 72 taps.
// - Programmable FIR gain is +6, 0, -6 or -12 dB.
// - Processing clock is ADC clock over four for cascade, five for dec-by-five.
// - All stages saturate, intermediate and output data never wrap.
// - Output is zero-IF I/Q or low-IF complex through independent paths.
// - IF stage has two bands, each with two mixers, resampling and half-band.
// - IF half-band uses fixed symmetric taps, centre one half, neighbours 0.3168.
// - Band A first oscillator centres signal at zero, optional half-band halves rate when RDC_BB_DEC2 is set.
// - Real-IF output sends only in-phase samples, quadrature dropped.
//
// The register offsets and the APB slave port were decided locally.
module rdc_decimation_chain
  import rdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_valid,
  input wire logic signed [RDC_DW-1:0] adc_i,
  input wire logic signed [RDC_DW-1:0] adc_q,
  output logic out_valid,
  output logic signed [RDC_DW-1:0] out_i,
  output logic signed [RDC_DW-1:0] out_q,
  output logic out_real,
  output logic dp_tick
);
  typedef struct packed {
    logic [RDC_CTRL_W-1:0] ctrl;
    logic [1:0][RDC_BAND_W-1:0] band;
    logic [1:0][31:0] freq;
    logic [6:0] caddr;
    logic [RDC_PROGRAMMABLE_FIR_N-1:0][RDC_CW-1:0] coef;
    logic [15:0] cnt;
    logic clip;
    logic [2:0] div;
    logic tick;
    logic [1:0] pend;
    logic [RDC_DW-1:0] hold_bi;
    logic [RDC_DW-1:0] hold_bq;
    logic ov;
    logic [RDC_DW-1:0] oi;
    logic [RDC_DW-1:0] oq;
    logic oreal;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rdc_top_state_type;

  rdc_top_state_type s_reg;
  rdc_top_state_type s_next;

  logic [RDC_DECIMATE_BY_FIVE_FILTER_N-1:0][RDC_CW-1:0] decimate_by_five_filter_coef;
  logic [RDC_BINO_N-1:0][RDC_CW-1:0] bino_coef;
  logic [RDC_HB3_N-1:0][RDC_CW-1:0] hb3_coef;
  logic [RDC_HB2_N-1:0][RDC_CW-1:0] hb2_coef;
  logic [RDC_HB1_N-1:0][RDC_CW-1:0] hb1_coef;
  logic [RDC_IFHB_N-1:0][RDC_CW-1:0] ifhb_coef;

  always_comb
  begin
    for (int k = 0; k < RDC_DECIMATE_BY_FIVE_FILTER_N; k++)
      decimate_by_five_filter_coef[k] = RDC_CW'(RDC_DECIMATE_BY_FIVE_FILTER_C[k]);
    for (int k = 0; k < RDC_BINO_N; k++)
      bino_coef[k] = RDC_CW'(RDC_BINO_C[k]);
    for (int k = 0; k < RDC_HB3_N; k++)
      hb3_coef[k] = RDC_CW'(RDC_HB3_C[k]);
    for (int k = 0; k < RDC_HB2_N; k++)
      hb2_coef[k] = RDC_CW'(RDC_HB2_C[k]);
    for (int k = 0; k < RDC_HB1_N; k++)
      hb1_coef[k] = s_reg.ctrl[RDC_CB_WIDE] ? RDC_CW'(RDC_HB1HR_C[k]) :
                    RDC_CW'(RDC_HB1LP_C[k]);
    for (int k = 0; k < RDC_IFHB_N; k++)
      ifhb_coef[k] = RDC_CW'(RDC_IFHB_C[k]);
  end

  logic use_decimate_by_five_filter;
  assign use_decimate_by_five_filter = s_reg.ctrl[RDC_CB_DECIMATE_BY_FIVE_FILTER];

  logic d5_v, eb_v, lb_v, h3_v, h2_v, h1_v, pf_v;
  logic signed [RDC_DW-1:0] d5_i, d5_q, eb_i, eb_q, lb_i, lb_q, h3_i, h3_q;
  logic signed [RDC_DW-1:0] h2_i, h2_q, h1_i, h1_q, pf_i, pf_q;
  logic fr_v;
  logic signed [RDC_DW-1:0] fr_i, fr_q;
  logic [6:0] clips;

  rdc_fir_stage #(.NT(RDC_DECIMATE_BY_FIVE_FILTER_N)) u_decimate_by_five_filter (
    .clk(clk), .rst_n(rst_n), .in_valid(adc_valid & use_decimate_by_five_filter), .in_i(adc_i), .in_q(adc_q),
    .bypass(1'b0), .decim(RDC_DECIM_5), .ntaps(7'(RDC_DECIMATE_BY_FIVE_FILTER_N)), .shift(RDC_SH_DECIMATE_BY_FIVE_FILTER),
    .coef(decimate_by_five_filter_coef), .out_valid(d5_v), .out_i(d5_i), .out_q(d5_q), .clip(clips[0]));

  rdc_fir_stage #(.NT(RDC_BINO_N)) u_early (
    .clk(clk), .rst_n(rst_n), .in_valid(adc_valid & ~use_decimate_by_five_filter), .in_i(adc_i), .in_q(adc_q),
    .bypass(~s_reg.ctrl[RDC_CB_EARLY]), .decim(RDC_DECIM_2), .ntaps(7'(RDC_BINO_N)),
    .shift(RDC_SH_BINO), .coef(bino_coef), .out_valid(eb_v), .out_i(eb_i), .out_q(eb_q),
    .clip(clips[1]));

  rdc_fir_stage #(.NT(RDC_BINO_N)) u_late (
    .clk(clk), .rst_n(rst_n), .in_valid(eb_v), .in_i(eb_i), .in_q(eb_q),
    .bypass(~s_reg.ctrl[RDC_CB_LATE]), .decim(RDC_DECIM_2), .ntaps(7'(RDC_BINO_N)),
    .shift(RDC_SH_BINO), .coef(bino_coef), .out_valid(lb_v), .out_i(lb_i), .out_q(lb_q),
    .clip(clips[2]));

  rdc_fir_stage #(.NT(RDC_HB3_N)) u_hb3 (
    .clk(clk), .rst_n(rst_n), .in_valid(lb_v), .in_i(lb_i), .in_q(lb_q),
    .bypass(1'b0), .decim(RDC_DECIM_2), .ntaps(7'(RDC_HB3_N)), .shift(RDC_SH_HB3),
    .coef(hb3_coef), .out_valid(h3_v), .out_i(h3_i), .out_q(h3_q), .clip(clips[3]));

  // exactly one front path feeds on
  assign fr_v = use_decimate_by_five_filter ? d5_v : h3_v;
  assign fr_i = use_decimate_by_five_filter ? d5_i : h3_i;
  assign fr_q = use_decimate_by_five_filter ? d5_q : h3_q;

  rdc_fir_stage #(.NT(RDC_HB2_N)) u_hb2 (
    .clk(clk), .rst_n(rst_n), .in_valid(fr_v), .in_i(fr_i), .in_q(fr_q),
    .bypass(~s_reg.ctrl[RDC_CB_HB2]), .decim(RDC_DECIM_2), .ntaps(7'(RDC_HB2_N)),
    .shift(RDC_SH_HB2), .coef(hb2_coef), .out_valid(h2_v), .out_i(h2_i), .out_q(h2_q),
    .clip(clips[4]));

  // first half-band, variant chosen by the wide control bit
  rdc_fir_stage #(.NT(RDC_HB1_N)) u_hb1 (
    .clk(clk), .rst_n(rst_n), .in_valid(h2_v), .in_i(h2_i), .in_q(h2_q),
    .bypass(~s_reg.ctrl[RDC_CB_HB1]), .decim(RDC_DECIM_2),
    .ntaps(s_reg.ctrl[RDC_CB_WIDE] ? 7'(RDC_HB1_N) : 7'(RDC_HB1LP_N)),
    .shift(RDC_SH_HB1), .coef(hb1_coef), .out_valid(h1_v), .out_i(h1_i), .out_q(h1_q),
    .clip(clips[5]));

  logic [1:0] pdec;
  logic [1:0] ptap;
  logic [1:0] pgain;
  logic [2:0] pf_decim;
  logic [6:0] pf_taps;
  logic [4:0] pf_shift;
  assign pdec = s_reg.ctrl[RDC_CB_PDEC +: 2];
  assign ptap = s_reg.ctrl[RDC_CB_PTAP +: 2];
  assign pgain = s_reg.ctrl[RDC_CB_GAIN +: 2];

  always_comb
  begin
    // code 0 bypass, then 1, 2, 4
    unique case (pdec)
      2'h2: pf_decim = RDC_DECIM_2;
      2'h3: pf_decim = RDC_DECIM_4;
      default: pf_decim = RDC_DECIM_1;
    endcase
    unique case (ptap)
      2'h0: pf_taps = RDC_TAPS_24;
      2'h1: pf_taps = RDC_TAPS_48;
      default: pf_taps = RDC_TAPS_72;
    endcase
    unique case (pgain)
      2'h0: pf_shift = RDC_SH_P6;
      2'h1: pf_shift = RDC_SH_0;
      2'h2: pf_shift = RDC_SH_M6;
      default: pf_shift = RDC_SH_M12;
    endcase
  end

  rdc_fir_stage #(.NT(RDC_PROGRAMMABLE_FIR_N)) u_programmable_fir (
    .clk(clk), .rst_n(rst_n), .in_valid(h1_v), .in_i(h1_i), .in_q(h1_q),
    .bypass(pdec == 2'h0), .decim(pf_decim), .ntaps(pf_taps), .shift(pf_shift),
    .coef(s_reg.coef), .out_valid(pf_v), .out_i(pf_i), .out_q(pf_q), .clip(clips[6]));

  logic [1:0] m1_v, hb_v, m2_v, hbin_v, band_clip;
  logic [1:0][RDC_DW-1:0] m1_i, m1_q, hb_i, hb_q, m2_i, m2_q, hbin_i, hbin_q;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_band
      rdc_shift_osc u_osc1 (
        .clk(clk), .rst_n(rst_n), .in_valid(pf_v), .in_i(pf_i), .in_q(pf_q),
        .enable(s_reg.band[g][RDC_BB_OSC1]), .freq(s_reg.freq[g][15:0]),
        .out_valid(m1_v[g]), .out_i(m1_i[g]), .out_q(m1_q[g]));
      assign hbin_v[g] = m1_v[g] | s_reg.pend[g];
      assign hbin_i[g] = m1_v[g] ? m1_i[g] : '0;
      assign hbin_q[g] = m1_v[g] ? m1_q[g] : '0;
      // half-band with optional decimate by two
      rdc_fir_stage #(.NT(RDC_IFHB_N)) u_ifhb (
        .clk(clk), .rst_n(rst_n), .in_valid(hbin_v[g]), .in_i(hbin_i[g]),
        .in_q(hbin_q[g]), .bypass(~s_reg.band[g][RDC_BB_HB]),
        .decim(s_reg.band[g][RDC_BB_DEC2] ? RDC_DECIM_2 : RDC_DECIM_1),
        .ntaps(7'(RDC_IFHB_N)), .shift(RDC_SH_IFHB), .coef(ifhb_coef),
        .out_valid(hb_v[g]), .out_i(hb_i[g]), .out_q(hb_q[g]), .clip(band_clip[g]));
      rdc_shift_osc u_osc2 (
        .clk(clk), .rst_n(rst_n), .in_valid(hb_v[g]), .in_i(hb_i[g]), .in_q(hb_q[g]),
        .enable(s_reg.band[g][RDC_BB_OSC2]), .freq(s_reg.freq[g][31:16]),
        .out_valid(m2_v[g]), .out_i(m2_i[g]), .out_q(m2_q[g]));
    end
  endgenerate

  always_comb
  begin
    logic setup;
    logic access;
    logic hit;
    logic [31:0] rd;
    logic clr;
    logic signed [RDC_AW-1:0] sum_i;
    logic signed [RDC_AW-1:0] sum_q;
    setup = psel & ~penable;
    access = psel & penable & s_reg.pready;
    hit = 1'b1;
    rd = '0;
    clr = 1'b0;
    sum_i = '0;
    sum_q = '0;
    s_next = s_reg;

    // processing tick, divide by four or five
    s_next.tick = 1'b0;
    if (3'(s_reg.div + 3'h1) >= (use_decimate_by_five_filter ? RDC_DPDIV_DECIMATE_BY_FIVE_FILTER : RDC_DPDIV_CASCADE))
    begin
      s_next.div = 3'h0;
      s_next.tick = 1'b1;
    end
    else
      s_next.div = 3'(s_reg.div + 3'h1);

    for (int b = 0; b < 2; b++)
      s_next.pend[b] = m1_v[b] & s_reg.band[b][RDC_BB_INTERP];

    // band B held so a dual sum can use its latest sample
    if (m2_v[1])
    begin
      s_next.hold_bi = m2_i[1];
      s_next.hold_bq = m2_q[1];
    end

    // band A output, optionally summed with band B
    s_next.ov = m2_v[0];
    if (m2_v[0])
    begin
      sum_i = RDC_AW'($signed(m2_i[0]));
      sum_q = RDC_AW'($signed(m2_q[0]));
      if (s_reg.ctrl[RDC_CB_DUAL])
      begin
        sum_i = sum_i + RDC_AW'($signed(s_reg.hold_bi));
        sum_q = sum_q + RDC_AW'($signed(s_reg.hold_bq));
      end
      s_next.oi = rdc_sat16(sum_i);
      s_next.oq = s_reg.ctrl[RDC_CB_REAL] ? '0 : rdc_sat16(sum_q);
      s_next.cnt = 16'(s_reg.cnt + 16'h0001);
    end
    s_next.oreal = s_reg.ctrl[RDC_CB_REAL];

    unique case (paddr)
      RDC_OFF_CTRL: rd = 32'(s_reg.ctrl);
      RDC_OFF_BAND_A: rd = 32'(s_reg.band[0]);
      RDC_OFF_BAND_B: rd = 32'(s_reg.band[1]);
      RDC_OFF_FREQ_A: rd = s_reg.freq[0];
      RDC_OFF_FREQ_B: rd = s_reg.freq[1];
      RDC_OFF_COEF_ADDR: rd = 32'(s_reg.caddr);
      RDC_OFF_COEF_DATA: rd = 32'($signed(s_reg.coef[s_reg.caddr]));
      RDC_OFF_STATUS: rd = {15'h0000, s_reg.clip, s_reg.cnt};
      default: hit = 1'b0;
    endcase
    s_next.pready = setup;
    s_next.pslverr = setup & ~hit;
    if (setup)
      s_next.prdata = hit ? rd : '0;

    if (access & pwrite & hit)
    begin
      unique case (paddr)
        RDC_OFF_CTRL: s_next.ctrl = pwdata[RDC_CTRL_W-1:0];
        RDC_OFF_BAND_A: s_next.band[0] = pwdata[RDC_BAND_W-1:0];
        RDC_OFF_BAND_B: s_next.band[1] = pwdata[RDC_BAND_W-1:0];
        RDC_OFF_FREQ_A: s_next.freq[0] = pwdata;
        RDC_OFF_FREQ_B: s_next.freq[1] = pwdata;
        RDC_OFF_COEF_ADDR: s_next.caddr = pwdata[6:0];
        RDC_OFF_COEF_DATA:
        begin
          if (s_reg.caddr < 7'(RDC_PROGRAMMABLE_FIR_N))
            s_next.coef[s_reg.caddr] = pwdata[RDC_CW-1:0];
          // auto-increment keeps bulk loads to one write per tap
          s_next.caddr = 7'(s_reg.caddr + 7'h01);
        end
        RDC_OFF_STATUS: clr = pwdata[RDC_ST_CLIP];
        default: clr = 1'b0;
      endcase
    end
    // a clip in the clearing cycle survives
    s_next.clip = (s_reg.clip & ~clr) | (|clips) | (|band_clip);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.ctrl <= RDC_CTRL_RST;
    end
    else
      s_reg <= s_next;
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign out_valid = s_reg.ov;
  assign out_i = s_reg.oi;
  assign out_q = s_reg.oq;
  assign out_real = s_reg.oreal;
  assign dp_tick = s_reg.tick;
endmodule // rdc_decimation_chain

// File: src/rdc_shift_osc.sv
module rdc_shift_osc
  import rdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic signed [RDC_DW-1:0] in_i,
  input wire logic signed [RDC_DW-1:0] in_q,
  input wire logic enable,
  input wire logic [15:0] freq,
  output logic out_valid,
  output logic signed [RDC_DW-1:0] out_i,
  output logic signed [RDC_DW-1:0] out_q
);
  typedef struct packed {
    logic [15:0] phase;
    logic ov;
    logic [RDC_DW-1:0] oi;
    logic [RDC_DW-1:0] oq;
  } rdc_osc_state_type;

  rdc_osc_state_type s_reg;
  rdc_osc_state_type s_next;

  always_comb
  begin
    logic signed [RDC_DW-1:0] c;
    logic signed [RDC_DW-1:0] sn;
    logic signed [RDC_AW-1:0] ri;
    logic signed [RDC_AW-1:0] rq;
    c = RDC_DW'(RDC_COS_LUT[s_reg.phase[15:12]]);
    sn = RDC_DW'(RDC_COS_LUT[4'(s_reg.phase[15:12] + RDC_SIN_OFS)]);
    ri = RDC_AW'(in_i * c) - RDC_AW'(in_q * sn);
    rq = RDC_AW'(in_i * sn) + RDC_AW'(in_q * c);
    s_next = s_reg;
    s_next.ov = in_valid;
    if (in_valid)
    begin
      // same one-cycle latency enabled or not, so strobes stay aligned
      if (enable)
      begin
        s_next.oi = rdc_sat16(ri >>> RDC_OSC_SH);
        s_next.oq = rdc_sat16(rq >>> RDC_OSC_SH);
        s_next.phase = 16'(s_reg.phase + freq);
      end
      else
      begin
        s_next.oi = in_i;
        s_next.oq = in_q;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign out_valid = s_reg.ov;
  assign out_i = s_reg.oi;
  assign out_q = s_reg.oq;
endmodule // rdc_shift_osc

// File: test/rdc_chain_sva.sv
module rdc_chain_sva
  import rdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic out_valid,
  input wire logic signed [RDC_DW-1:0] out_i,
  input wire logic signed [RDC_DW-1:0] out_q,
  input wire logic out_real,
  input wire logic dp_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] quiet_reg;
  // divider phase may jump when the path is switched, so rest after writes
  always_ff @(posedge clk)
  begin
    if (!rst_n || (psel && pwrite))
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf)
      quiet_reg <= quiet_reg + 4'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ready_after_setup_a:
    assert property (psel && !penable |=> pready) else $error("no pready");
  ready_has_cause_a:
    assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
  err_with_ready_a:
    assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad slverr");
  real_drops_q_a:
    assert property (out_valid && out_real |-> out_q == 16'sh0) else $error("q in real");
  output_holds_a:
    assert property (!out_valid |-> $stable(out_i)) else $error("out_i moved");
  reset_quiet_a:
    assert property ($rose(rst_n) |-> !out_valid && !dp_tick && !pready) else $error("rst");
  tick_gap_a:
    assert property (disable iff (!rst_n || quiet_reg != 4'hf)
      dp_tick |=> !dp_tick [*3]) else $error("tick early");
  tick_period_a:
    assert property (disable iff (!rst_n || quiet_reg != 4'hf)
      dp_tick |-> ##[4:5] dp_tick) else $error("tick late");
  cover property (out_valid && out_real);
  cover property (pslverr);
  cover property (dp_tick ##5 dp_tick);
endmodule // rdc_chain_sva

bind rdc_decimation_chain rdc_chain_sva i_sva (.clk, .rst_n, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .out_valid, .out_i, .out_q, .out_real, .dp_tick);

// File: test/rdc_sink_model.sv
module rdc_sink_model
  import rdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic out_valid,
  input wire logic signed [RDC_DW-1:0] out_i,
  input wire logic signed [RDC_DW-1:0] out_q
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_seen;
  logic signed [RDC_DW-1:0] last_i;
  logic signed [RDC_DW-1:0] last_q;
  // framer takes each pair on its strobe, never pushes back
  always @(posedge clk)
  begin
    if (!rst_n)
      n_seen <= 0;
    else if (out_valid)
    begin
      n_seen <= n_seen + 1;
      last_i <= out_i;
      last_q <= out_q;
    end
  end
endmodule // rdc_sink_model

// File: test/test_rx_decimation_filter_chain.sv
module test_rx_decimation_filter_chain;
  import rdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic adc_valid = 1'b0, pready, pslverr, out_valid, out_real, dp_tick, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic signed [RDC_DW-1:0] adc_i = 16'sh0, adc_q = 16'sh0, out_i, out_q;
  int n_errors = 0, checks = 0, base, k, t;
  // taps within clock budget, zero-IF bands only
  int cfg [13] = '{16'h0, 16'h2, 16'h6, 16'h1, 16'h3, 16'hc1, 16'h8, 16'h10, 16'h30,
    16'h146, 16'h28e, 16'h1e, 16'h1000};
  int dec [13] = '{2, 4, 8, 5, 5, 20, 4, 4, 4, 8, 32, 32, 2};
  rdc_decimation_chain i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .adc_valid, .adc_i, .adc_q, .out_valid, .out_i, .out_q,
    .out_real, .dp_tick);
  rdc_sink_model i_sink (.clk, .rst_n, .out_valid, .out_i, .out_q);
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic print_verdict();
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16)
    begin
      n_errors++;
      print_verdict();
    end
  endtask
  // flush time covers the deepest pipeline plus the longest decimation
  task automatic feed(input int n, input int v);
    repeat (n)
    begin
      @(posedge clk);
      adc_valid <= 1'b1;
      adc_i <= 16'(v);
      adc_q <= 16'(-v);
    end
    @(posedge clk);
    adc_valid <= 1'b0;
    repeat (60) @(posedge clk);
  endtask
  // third half-band dc gain 1016/1024, tap0 = 1.0, gain code g halves from +6 dB
  function automatic int model(input int kk, input int g);
    int x;
    x = (2032 * kk) >>> g;
    return x > 32767 ? 32767 : (x < -32768 ? -32768 : x);
  endfunction
  initial
  begin
    k = $urandom(35700);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, RDC_OFF_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("slverr", err, 1'b1);
    for (int i = 0; i < 13; i++)
    begin
      apb(1'b1, RDC_OFF_CTRL, cfg[i]);
      base = i_sink.n_seen;
      feed(320, (int'($urandom_range(30)) - 15) * 1024);
      check("count", i_sink.n_seen - base, 320 / dec[i]);
      t = 0;
      repeat (20)
      begin
        @(posedge clk);
        t += int'(dp_tick);
      end
      check("dp_tick", t, cfg[i][0] ? 4 : 5);
      check("out_real", out_real, cfg[i][12]);
      if (cfg[i][12])
        check("out_q", i_sink.last_q, 32'h0);
    end
    apb(1'b1, RDC_OFF_COEF_ADDR, 32'h0);
    apb(1'b1, RDC_OFF_COEF_DATA, 32'h8000);
    for (int j = 0; j < 5; j++)
    begin
      k = j == 4 ? 20 : int'($urandom_range(30)) - 15;
      // binomials decimate too, so 24 taps stay within the clock budget
      apb(1'b1, RDC_OFF_CTRL, 32'h46 | (j % 4) << 10);
      feed(64, k * 1024);
      check("out_i", i_sink.last_i, model(k, j % 4));
      check("out_q", i_sink.last_q, model(-k, j % 4));
    end
    // band A re-centre, half-band, halve rate
    apb(1'b1, RDC_OFF_BAND_A, 32'hd);
    base = i_sink.n_seen;
    t = 0;
    for (int n = 0; n < RDC_IFHB_N; n++)
      t += RDC_IFHB_C[n];
    feed(1024, 1024);
    check("count", i_sink.n_seen - base, 1024 / 16);
    k = model(1, 0) * RDC_COS_LUT[0] >>> RDC_OSC_SH;
    check("out_i", i_sink.last_i, k * t >>> RDC_SH_IFHB);
    k = model(-1, 0) * RDC_COS_LUT[0] >>> RDC_OSC_SH;
    check("out_q", i_sink.last_q, k * t >>> RDC_SH_IFHB);
    apb(1'b0, RDC_OFF_STATUS, 32'h0);
    check("clip", rd[16], 1'b1);
    check("status", rd[15:0], i_sink.n_seen & 32'hffff);
    apb(1'b1, RDC_OFF_STATUS, 32'h10000);
    apb(1'b0, RDC_OFF_STATUS, 32'h0);
    check("clip", rd[16], 1'b0);
    print_verdict();
  end
endmodule // test_rx_decimation_filter_chain
